// ### hdl/csb_core.sv
// Purpose: Buffer status, slot timing and serial modes of a codec link.
// Assumes: Frame sync is generated here; bit clock internal or external.
// Notes:   Bit clock and serial input are sampled by the system clock.

`timescale 1ns/1ns
// ============================================================
// Contract
// R1: Transfer sets tx empty; buffer write clears.
// R2: Transfer sets underflow for unrefreshed words.
// R3: Words beyond buffer length never touch flags; a write to one still clears tx empty.
// R4: Rx full set fresh, clears after all read.
// R5: Overflow set on unread word, cleared reading.
// R6: Overflow overwrites old receive word contents.
// R7: Slot index shows frame generator slot count.
// R8: Tx slot unused when its enable zero.
// R9: Unused slot drives low, or releases line.
// R10: Shared line devices never drive same slot.
// R11: Loopback feeds output back, ignores input pin.
// R12: Underflow sends zeros, or repeats last write.
// R13: Interrupt pulse on every shadow transfer.
// R14: Transfer moves tx and rx words together.
// R15: External clock keeps running, sleep wake pulse.
// R16: Idle stop select halts during cpu idle.
// R17: AC frame 256 bits, sync 16 high.
// R18: Mode field: 01 I2S, 10/11 AC-Link.
// R19: AC16 keeps 16 bits, zero tail bits.
// R20: AC20 acts as sixteen 16-bit slots.
// R21: I2S sync 50% duty, each edge word.
// R22: Buffer pointer follows enabled slots, not frames.
// R23: Pointer equals length: wrap and transfer.
// R24: Reset clears flags, slot, pointer, output idle.
module csb_core #(
    parameter int unsigned HALF_CYC = csb_pkg::BCLK_HALF_CYC
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         enable_i,
    input  wire logic [1:0]                   frame_sync_mode_field_i,
    input  wire logic [1:0]                   buffer_length_field_i,
    input  wire logic [3:0]                   frame_length_field_i,
    input  wire logic [3:0]                   word_size_field_i,
    input  wire logic [csb_pkg::NSLOT-1:0]    tx_slot_enable_i,
    input  wire logic [csb_pkg::NSLOT-1:0]    rx_slot_enable_i,
    input  wire logic                         output_idle_select_i,
    input  wire logic                         loopback_select_i,
    input  wire logic                         underflow_repeat_select_i,
    input  wire logic                         idle_stop_select_i,
    input  wire logic                         bit_clock_direction_i,
    input  wire logic                         cpu_idle_i,
    input  wire logic                         cpu_sleep_i,
    input  wire logic                         tx_wr_i,
    input  wire logic [csb_pkg::PTR_W-1:0]    tx_addr_i,
    input  wire logic [csb_pkg::DATA_W-1:0]   tx_wdata_i,
    input  wire logic                         rx_rd_i,
    input  wire logic [csb_pkg::PTR_W-1:0]    rx_addr_i,
    output logic [csb_pkg::DATA_W-1:0]        rx_rdata_o,
    input  wire logic                         bit_clock_pin_i,
    output logic                              bit_clock_pin_o,
    input  wire logic                         serial_data_in_i,
    output logic                              serial_data_out_o,
    output logic                              serial_data_out_oe_o,
    output logic                              frame_sync_pin_o,
    output logic                              tx_empty_flag_o,
    output logic                              tx_underflow_flag_o,
    output logic                              rx_full_flag_o,
    output logic                              rx_overflow_flag_o,
    output logic [csb_pkg::SLOT_W-1:0]        slot_index_o,
    output logic                              irq_o,
    output logic                              wake_o
);
    import csb_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        logic                         bclk_s1;
        logic                         bclk_s2;
        logic                         sdi_s1;
        logic                         sdi_s2;
        logic                         bclk_int;
        logic [BCLK_CNT_W-1:0]        bclk_cnt;
        logic                         bclk_q;
        logic                         started;
        logic [BIT_W-1:0]             bitc;
        logic [SLOT_W-1:0]            slot;
        logic                         half;
        logic                         fsync;
        logic                         tx_act;
        logic                         sdo;
        logic                         sdo_oe;
        logic [PTR_W-1:0]             ptr;
        logic [DATA_W-1:0]            tx_word;
        logic [DATA_W-1:0]            rx_sh;
        logic [NBUF-1:0][DATA_W-1:0]  tx_buffer_word;
        logic [NBUF-1:0][DATA_W-1:0]  txsh;
        logic [NBUF-1:0][DATA_W-1:0]  rxsh;
        logic [NBUF-1:0][DATA_W-1:0]  rx_buffer_word;
        logic [NBUF-1:0]              fresh;
        logic [NBUF-1:0]              unf;
        logic [NBUF-1:0]              unread;
        logic [NBUF-1:0]              ovf;
        logic                         empty;
        logic                         xfer_pend;
        logic [DATA_W-1:0]            rdata;
        logic                         irq;
        logic                         wake;
    } csb_state_t;

    csb_state_t              s;
    csb_state_t              next_s;
    csb_mode_t               mode;
    logic                    halt;
    logic                    bclk;
    logic                    launch;
    logic                    capture;
    logic                    din;
    logic                    push;
    logic                    xfer;
    logic                    slot_used;
    logic [BIT_W-1:0]        last_bit;
    logic [SLOT_W-1:0]       last_slot;
    logic [DATA_W-1:0]       tx_pick;
    logic [3:0]              shamt;
    logic [NBUF-1:0]         mask;
    logic                    buf_in_ready;
    logic                    buf_out_valid;
    logic [PTR_W+DATA_W-1:0] buf_in_data;
    logic [PTR_W+DATA_W-1:0] buf_out_data;

    // ============================================================
    // Timing decode
    always_comb begin
        mode = csb_mode_t'(frame_sync_mode_field_i); // R18
        case (mode)
            MODE_AC16: begin
                last_bit  = (s.slot == HEAD_SLOT) ? BIT_WORD_LAST
                                                  : BIT_WIDE_LAST; // R17
                last_slot = AC16_LAST_SLOT;
            end
            MODE_AC20: begin
                last_bit  = BIT_WORD_LAST; // R20
                last_slot = AC20_LAST_SLOT;
            end
            default: begin
                last_bit  = {1'b0, word_size_field_i};
                last_slot = frame_length_field_i;
            end
        endcase
        shamt = (last_bit >= BIT_WORD_LAST) ? 4'h0
                : 4'(BIT_WORD_LAST - last_bit);
        for (int i = 0; i < NBUF; i++) begin
            mask[i] = (PTR_W'(i) <= buffer_length_field_i); // R3
        end
    end

    // An internal bit clock stops in sleep; an external one keeps going.
    assign halt = !enable_i
                | (idle_stop_select_i & cpu_idle_i) // R16
                | (cpu_sleep_i & !bit_clock_direction_i); // R15
    assign bclk    = bit_clock_direction_i ? s.bclk_s2 : s.bclk_int;
    assign launch  = !halt && ((mode == MODE_I2S) ? (!bclk && s.bclk_q)
                                                  : (bclk && !s.bclk_q));
    assign capture = !halt && s.started
                     && ((mode == MODE_I2S) ? (bclk && !s.bclk_q)
                                            : (!bclk && s.bclk_q));
    assign din = loopback_select_i ? s.sdo : s.sdi_s2; // R11
    assign slot_used = tx_slot_enable_i[s.slot] | rx_slot_enable_i[s.slot];
    assign xfer = s.xfer_pend && !buf_out_valid;
    // A slot launched before a slow transfer must still get the new word.
    assign tx_pick = (s.fresh[s.ptr] | underflow_repeat_select_i)
                     ? s.tx_buffer_word[s.ptr] : '0; // R14

    // ============================================================
    // Received words wait here until the shadow store takes them.
    csb_fifo2 #(
        .W (PTR_W + DATA_W)
    ) u_rx_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (buf_out_valid),
        .out_ready_i (!halt),
        .out_data_o  (buf_out_data)
    );

    // ============================================================
    // Next state
    always_comb begin
        next_s = s;
        push = 1'b0;
        buf_in_data = '0;
        next_s.bclk_s1 = bit_clock_pin_i;
        next_s.bclk_s2 = s.bclk_s1;
        next_s.sdi_s1  = serial_data_in_i;
        next_s.sdi_s2  = s.sdi_s1;
        next_s.bclk_q  = bclk;
        next_s.irq  = 1'b0;
        next_s.wake = 1'b0;
        if (!halt) begin
            if (s.bclk_cnt == BCLK_CNT_W'(HALF_CYC - 1)) begin
                next_s.bclk_cnt = '0;
                next_s.bclk_int = !s.bclk_int;
            end else begin
                next_s.bclk_cnt = s.bclk_cnt + 1'b1;
            end
        end
        if (capture) begin
            if (s.bitc < BIT_DATA_W) begin
                next_s.rx_sh = {s.rx_sh[DATA_W-2:0], din}; // R19
            end
            if (s.bitc == last_bit) begin
                if (rx_slot_enable_i[s.slot] && buf_in_ready) begin
                    push = 1'b1;
                    buf_in_data = {s.ptr, next_s.rx_sh << shamt};
                end
                if (slot_used) begin // R22
                    if (s.ptr == buffer_length_field_i) begin // R23
                        next_s.ptr = '0;
                        next_s.xfer_pend = 1'b1;
                    end else begin
                        next_s.ptr = s.ptr + 1'b1;
                    end
                end
            end
        end
        if (launch) begin
            if (!s.started) begin
                next_s.started = 1'b1;
                next_s.bitc = '0;
                next_s.slot = '0;
            end else if (s.bitc >= last_bit) begin
                next_s.bitc = '0;
                if (s.slot >= last_slot) begin
                    next_s.slot = '0;
                    next_s.half = !s.half; // R21
                end else begin
                    next_s.slot = s.slot + 1'b1;
                end
            end else begin
                next_s.bitc = s.bitc + 1'b1;
            end
            if (next_s.bitc == '0) begin
                next_s.tx_act  = tx_slot_enable_i[next_s.slot]; // R8
                next_s.tx_word = s.xfer_pend ? tx_pick : s.txsh[s.ptr];
            end
            next_s.sdo = next_s.tx_act && (next_s.bitc < BIT_DATA_W)
                && next_s.tx_word[DATA_MSB - next_s.bitc[3:0]]; // R19
            next_s.sdo_oe = next_s.tx_act | !output_idle_select_i; // R9
            case (mode)
                MODE_I2S:   next_s.fsync = next_s.half; // R21
                MODE_MULTI: next_s.fsync = (next_s.slot == HEAD_SLOT)
                                           && (next_s.bitc == '0);
                default:    next_s.fsync = (next_s.slot == HEAD_SLOT); // R17
            endcase
        end
        if (buf_out_valid && !halt) begin
            next_s.rxsh[buf_out_data[DATA_W +: PTR_W]] =
                buf_out_data[DATA_W-1:0];
        end
        if (xfer) begin // R14
            next_s.xfer_pend = 1'b0;
            next_s.irq   = 1'b1; // R13
            next_s.wake  = cpu_sleep_i & bit_clock_direction_i; // R15
            next_s.empty = 1'b1; // R1
            for (int i = 0; i < NBUF; i++) begin
                if (mask[i]) begin // R3
                    next_s.txsh[i] = (s.fresh[i] | underflow_repeat_select_i)
                                     ? s.tx_buffer_word[i] : '0; // R12
                    next_s.unf[i]    = s.unf[i] | !s.fresh[i]; // R2
                    next_s.fresh[i]  = 1'b0;
                    next_s.rx_buffer_word[i]  = s.rxsh[i]; // R6
                    next_s.ovf[i]    = s.ovf[i] | s.unread[i]; // R5
                    next_s.unread[i] = 1'b1; // R4
                end
            end
        end
        // A flag set by a transfer wins over a clear in the same cycle.
        if (tx_wr_i) begin
            next_s.tx_buffer_word[tx_addr_i] = tx_wdata_i;
            next_s.fresh[tx_addr_i] = 1'b1;
            if (!xfer) begin
                next_s.empty = 1'b0; // R1
                next_s.unf[tx_addr_i] = 1'b0; // R2
            end
        end
        if (rx_rd_i) begin
            next_s.rdata = s.rx_buffer_word[rx_addr_i];
            if (!xfer) begin
                next_s.unread[rx_addr_i] = 1'b0; // R4
                next_s.ovf[rx_addr_i] = 1'b0; // R5
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0; // R24
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    assign rx_rdata_o           = s.rdata;
    assign bit_clock_pin_o      = s.bclk_int;
    assign serial_data_out_o    = s.sdo;
    assign serial_data_out_oe_o = s.sdo_oe;
    assign frame_sync_pin_o     = s.fsync;
    assign tx_empty_flag_o      = s.empty;
    assign tx_underflow_flag_o  = |(s.unf & mask); // R3
    assign rx_full_flag_o       = |(s.unread & mask);
    assign rx_overflow_flag_o   = |(s.ovf & mask);
    assign slot_index_o         = s.slot; // R7
    assign irq_o                = s.irq;
    assign wake_o               = s.wake;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_empty_set_xfer: assert property (xfer |=> tx_empty_flag_o) // R1
        else $error("tx empty not set by transfer");
    a_empty_clr_wr: assert property (tx_wr_i && !xfer // R1
        |=> !tx_empty_flag_o) else $error("tx empty not cleared by write");
    a_unf_set: assert property (xfer && |(mask & ~s.fresh) // R2
        |=> tx_underflow_flag_o) else $error("underflow missed");
    a_full_set: assert property (xfer |=> rx_full_flag_o) // R4
        else $error("rx full not set");
    a_ovf_set: assert property (xfer && |(mask & s.unread) // R5
        |=> rx_overflow_flag_o) else $error("overflow missed");
    a_irq_pulse: assert property (xfer |=> irq_o ##1 !irq_o) // R13
        else $error("interrupt not one pulse per transfer");
    a_idle_line: assert property (!s.tx_act |-> !serial_data_out_o) // R9
        else $error("unused slot drives data");
    a_active_drive: assert property (s.tx_act |-> serial_data_out_oe_o) // R9
        else $error("active slot not driven");
    a_halt_freeze: assert property (halt |=> $stable(s.bitc)) // R16
        else $error("counters moved while halted");
    a_wake_cause: assert property (wake_o |-> $past(xfer) // R15
        && $past(cpu_sleep_i)) else $error("stray wake");
    a_ptr_wrap: assert property (capture && s.bitc == last_bit // R23
        && slot_used && s.ptr == buffer_length_field_i
        |=> s.ptr == '0 && s.xfer_pend) else $error("no wrap");

    c_transfer: cover property (xfer);
    c_overflow: cover property (xfer && |(mask & s.unread));
    c_underflow: cover property (xfer && |(mask & ~s.fresh));
endmodule : csb_core

// ### hdl/csb_fifo2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock; fill and drain may happen in one cycle.
// Notes:   Full and empty are exact; a stalled drain fills it.

`timescale 1ns/1ns
// ============================================================
// Two-entry buffer
module csb_fifo2 #(
    parameter int unsigned W = 18
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } csb_fifo_t;

    csb_fifo_t s;
    csb_fifo_t next_s;
    logic      do_in;
    logic      do_out;

    assign in_ready_o  = (s.cnt != 2'h2);
    assign out_valid_o = (s.cnt != 2'h0);
    assign out_data_o  = s.mem[s.rp];
    assign do_in       = in_valid_i & in_ready_o;
    assign do_out      = out_valid_o & out_ready_i;

    always_comb begin
        next_s = s;
        if (do_in) begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp = ~s.wp;
        end
        if (do_out) begin
            next_s.rp = ~s.rp;
        end
        next_s.cnt = s.cnt + {1'b0, do_in} - {1'b0, do_out};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : csb_fifo2

// ### hdl/csb_pkg.sv
// Purpose: Shared constants and types for the codec serial buffer block.
// Assumes: 100 MHz system clock, 16-bit buffer words, four buffer words.
// Notes:   Times are in ns; cycle counts derive from them.

// ============================================================
// Package
package csb_pkg;
    localparam int unsigned SYS_PERIOD_NS  = 10;
    localparam int unsigned BCLK_PERIOD_NS = 80;
    localparam int unsigned BCLK_HALF_CYC  =
        (BCLK_PERIOD_NS / (2 * SYS_PERIOD_NS) > 0) ?
        BCLK_PERIOD_NS / (2 * SYS_PERIOD_NS) : 1;
    localparam int unsigned BCLK_CNT_W = 8;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned NBUF       = 4;
    localparam int unsigned PTR_W      = 2;
    localparam int unsigned SLOT_W     = 4;
    localparam int unsigned BIT_W      = 5;
    localparam int unsigned NSLOT      = 16;
    localparam logic [BIT_W-1:0]  BIT_WORD_LAST = 5'h0F;
    localparam logic [BIT_W-1:0]  BIT_WIDE_LAST = 5'h13;
    localparam logic [BIT_W-1:0]  BIT_DATA_W    = 5'h10;
    localparam logic [SLOT_W-1:0] AC16_LAST_SLOT = 4'hC;
    localparam logic [SLOT_W-1:0] AC20_LAST_SLOT = 4'hF;
    localparam logic [SLOT_W-1:0] HEAD_SLOT      = 4'h0;
    localparam logic [3:0]        DATA_MSB       = 4'hF;

    typedef enum logic [1:0] {
        MODE_MULTI = 2'b00,
        MODE_I2S   = 2'b01,
        MODE_AC16  = 2'b10,
        MODE_AC20  = 2'b11
    } csb_mode_t;
endpackage : csb_pkg

// ### verif/codec_serial_buffer_status_modes_tb.sv
// Purpose: Self-checking bench for the codec serial buffer core.
// Assumes: Internal bit clock at HALF_CYC of 1 unless noted.
// Notes:   Loopback data checks need no knowledge of codec data.
`timescale 1ns/1ns
module codec_serial_buffer_status_modes_tb;
    import csb_pkg::*;
    typedef struct {csb_mode_t m; logic [1:0] b; int fs; int gap;} csb_row_t;
    logic        clk_sys_i, rst_n_i, enable_i, output_idle_select_i;
    logic        loopback_select_i, underflow_repeat_select_i;
    logic        idle_stop_select_i, bit_clock_direction_i, cpu_idle_i;
    logic        cpu_sleep_i, tx_wr_i, rx_rd_i, bit_clock_pin_i;
    logic        serial_data_in_i, bit_clock_pin_o, serial_data_out_o;
    logic        serial_data_out_oe_o, frame_sync_pin_o, irq_o, wake_o;
    logic        tx_empty_flag_o, tx_underflow_flag_o, rx_full_flag_o;
    logic        rx_overflow_flag_o, run, woke;
    logic [1:0]  frame_sync_mode_field_i, buffer_length_field_i;
    logic [1:0]  tx_addr_i, rx_addr_i;
    logic [3:0]  frame_length_field_i, word_size_field_i, slot_index_o;
    logic [15:0] tx_slot_enable_i, rx_slot_enable_i, tx_wdata_i;
    logic [15:0] rx_rdata_o, txd [4], exp_rx [4];
    int          fail_count, checked, t, h, n;
    csb_row_t    rows [6] = '{'{MODE_MULTI, 2'h0, 2, 32},
        '{MODE_MULTI, 2'h1, 2, 64}, '{MODE_MULTI, 2'h3, 2, 128},
        '{MODE_I2S, 2'h1, 128, 64}, '{MODE_AC16, 2'h3, 32, 0},
        '{MODE_AC20, 2'h3, 32, 128}};

    csb_core #(.HALF_CYC(1)) uut (
        .clk_sys_i, .rst_n_i, .enable_i, .frame_sync_mode_field_i,
        .buffer_length_field_i, .frame_length_field_i,
        .word_size_field_i, .tx_slot_enable_i, .rx_slot_enable_i,
        .output_idle_select_i, .loopback_select_i,
        .underflow_repeat_select_i, .idle_stop_select_i,
        .bit_clock_direction_i, .cpu_idle_i, .cpu_sleep_i, .tx_wr_i,
        .tx_addr_i, .tx_wdata_i, .rx_rd_i, .rx_addr_i, .rx_rdata_o,
        .bit_clock_pin_i, .bit_clock_pin_o, .serial_data_in_i,
        .serial_data_out_o, .serial_data_out_oe_o, .frame_sync_pin_o,
        .tx_empty_flag_o, .tx_underflow_flag_o, .rx_full_flag_o,
        .rx_overflow_flag_o, .slot_index_o, .irq_o, .wake_o);

    csb_codec_model codec (.run_i(run), .bck_int_i(bit_clock_pin_o),
        .ext_i(bit_clock_direction_i), .bck_o(bit_clock_pin_i),
        .sdi_o(serial_data_in_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ============================================================
    // Helpers
    function automatic logic [3:0] flags();
        return {tx_empty_flag_o, tx_underflow_flag_o, rx_full_flag_o,
                rx_overflow_flag_o};
    endfunction : flags

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic tick_or_quit();
        @(negedge clk_sys_i);
        if (++t > 9000) begin
            chk(1'b0, "wait ran out");
            wrap_up();
        end
    endtask : tick_or_quit

    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
    endtask : do_reset

    // Flags change in the same cycle as the pulse; two more edges are left before returning.
    task automatic wait_irq(input int k);
        repeat (k) begin
            t = 0;
            tick_or_quit();
            while (irq_o !== 1'b1)
                tick_or_quit();
            woke = wake_o;
        end
        repeat (2) @(negedge clk_sys_i);
    endtask : wait_irq

    // The strobe is held across words so it never toggles in one step.
    task automatic wr_rng(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            tx_wr_i = 1'b1;
            tx_addr_i = 2'(i);
            tx_wdata_i = txd[i];
            @(negedge clk_sys_i);
        end
        tx_wr_i = 1'b0;
    endtask : wr_rng

    task automatic rd_rng(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            rx_rd_i = 1'b1;
            rx_addr_i = 2'(i);
            @(negedge clk_sys_i);
            chk(rx_rdata_o === exp_rx[i], "read data mismatch");
        end
        rx_rd_i = 1'b0;
        @(negedge clk_sys_i);
    endtask : rd_rng

    // ============================================================
    // Main sequence
    initial begin
        {rst_n_i, run, tx_wr_i, rx_rd_i, output_idle_select_i} = '0;
        {loopback_select_i, underflow_repeat_select_i, woke} = '0;
        {idle_stop_select_i, bit_clock_direction_i} = '0;
        {cpu_idle_i, cpu_sleep_i, tx_addr_i, rx_addr_i} = '0;
        {enable_i, tx_wdata_i, fail_count, checked} = '0;
        {frame_sync_mode_field_i, buffer_length_field_i} = '0;
        enable_i = 1'b1;
        {frame_length_field_i, word_size_field_i} = 8'h3F;
        {tx_slot_enable_i, rx_slot_enable_i} = 32'hFFFF_FFFF;
        txd = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
        do_reset();
        chk({flags(), slot_index_o, serial_data_out_oe_o} === 9'h0,
            "reset state");
        foreach (rows[i]) begin
            frame_sync_mode_field_i = rows[i].m;
            buffer_length_field_i = rows[i].b;
            do_reset();
            t = 0;
            while (frame_sync_pin_o !== 1'b1)
                tick_or_quit();
            if (rows[i].m == MODE_MULTI)
                chk(slot_index_o === 4'h0, "slot at frame start");
            for (h = 0; frame_sync_pin_o === 1'b1; h++)
                tick_or_quit();
            chk(h == rows[i].fs, "sync width");
            if (rows[i].gap > 0) begin
                wait_irq(1);
                wait_irq(1);
                chk(t + 2 == rows[i].gap, "irq spacing");
            end
        end
        frame_sync_mode_field_i = MODE_MULTI;
        tx_slot_enable_i = 16'h0;
        output_idle_select_i = 1'b1;
        do_reset();
        repeat (40) @(negedge clk_sys_i);
        chk(serial_data_out_oe_o === 1'b0, "idle line driven");
        output_idle_select_i = 1'b0;
        repeat (40) @(negedge clk_sys_i);
        chk({serial_data_out_oe_o, serial_data_out_o} === 2'b10,
            "idle line not low");
        tx_slot_enable_i = 16'h000F;
        loopback_select_i = 1'b1;
        do_reset();
        wr_rng(0, 3);
        wait_irq(1);
        chk(flags() === 4'b1010, "flags after first move");
        wait_irq(1);
        chk(flags() === 4'b1111, "flags after stale move");
        exp_rx = txd;
        rd_rng(0, 3);
        chk(flags() === 4'b1100, "flags after reads");
        wr_rng(0, 0);
        chk(flags() === 4'b0100, "flags after one write");
        txd[1:3] = '{16'h0F0F, 16'hA55A, 16'h7E81};
        wr_rng(1, 3);
        chk(flags() === 4'b0000, "underflow kept");
        wait_irq(1);
        exp_rx = '{default: 16'h0};
        rd_rng(0, 0);
        wait_irq(1);
        chk(flags() === 4'b1111, "overflow missing");
        exp_rx = txd;
        rd_rng(1, 3);
        chk(flags() === 4'b1110, "flags after part read");
        underflow_repeat_select_i = 1'b1;
        wait_irq(2);
        rd_rng(0, 3);
        buffer_length_field_i = 2'h0;
        do_reset();
        wait_irq(1);
        exp_rx[0] = 16'h0;
        wr_rng(0, 0);
        rd_rng(0, 0);
        chk(flags() === 4'b0000, "unused words counted");
        buffer_length_field_i = 2'h3;
        {idle_stop_select_i, cpu_idle_i} = 2'b11;
        n = 0;
        repeat (300) begin
            @(negedge clk_sys_i);
            n += int'(irq_o === 1'b1);
        end
        chk(n == 0, "ran while idle stopped");
        idle_stop_select_i = 1'b0;
        wait_irq(1);
        cpu_idle_i = 1'b0;
        {bit_clock_direction_i, run, cpu_sleep_i} = 3'b111;
        do_reset();
        wait_irq(1);
        chk(woke === 1'b1, "no wake in sleep");
        wrap_up();
    end
endmodule : codec_serial_buffer_status_modes_tb

// ### verif/csb_codec_model.sv
// Purpose: Far-side codec model that feeds the serial input line.
// Assumes: Its own bit clock has an 80 ns period while it runs.
// Notes:   The model clock idles low when it is not running.
`timescale 1ns/1ns
// ============================================================
// Codec model
module csb_codec_model (
    input  wire logic run_i,
    input  wire logic bck_int_i,
    input  wire logic ext_i,
    output logic      bck_o,
    output logic      sdi_o
);
    logic [15:0] pat;
    logic        bck;

    // The phase offset keeps its edges off the system clock edges.
    initial begin
        bck_o = 1'b0;
        #3;
        forever begin
            #40;
            bck_o = run_i ? ~bck_o : 1'b0;
        end
    end

    assign bck = ext_i ? bck_o : bck_int_i;

    // It drives only its own input line, never the shared output line.
    initial begin
        pat   = 16'hC35A;
        sdi_o = 1'b0;
    end
    always @(posedge bck) begin
        sdi_o <= pat[15];
        pat   <= {pat[14:0], pat[15]};
    end
endmodule : csb_codec_model
